//--- sim/pfs_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
// =========================================
// flash engine and host scan timing
module pfs_engine_model #(
   parameter int LAT  = 6,
   parameter int SCAN = 9
)(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // start requests
   input  wire logic save_start,
   input  wire logic init_start,
   input  wire logic fail,
   // answers
   output logic      engine_done,
   output logic      engine_fail,
   output logic      scan_end
);
   int cnt;
   int sc;
   // copy or restore takes LAT cycles
   always_ff @(posedge clk)
   begin
      sc <= (sc == SCAN - 1) ? 0 : sc + 1;
      if (!rst_n)
         cnt <= 0;
      else if (save_start || init_start)
         cnt <= LAT;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
   assign scan_end    = (sc == 0);
   assign engine_done = (cnt == 1);
   assign engine_fail = engine_done && fail;
endmodule : pfs_engine_model
`default_nettype wire

//--- sim/pfs_flash_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// =========================================
// result and interlock checks
module pfs_flash_ctrl_asserts (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // watched ports
   input wire logic        module_ready_flag,
   input wire logic        scan_end,
   input wire logic        save_start,
   input wire logic        init_start,
   input wire logic        busy,
   input wire logic        done_pulse,
   input wire logic        err_pulse,
   input wire logic [15:0] complete_code,
   input wire logic [15:0] system_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rise; $rose(done_pulse) |-> $past(scan_end); endproperty
   a_rise: assert property (p_rise) else $error("done rose off scan end");
   property p_fall; done_pulse && scan_end |=> !done_pulse; endproperty
   a_fall: assert property (p_fall) else $error("done held past scan end");
   property p_err; err_pulse |-> done_pulse; endproperty
   a_err: assert property (p_err) else $error("error without done");
   property p_ok; $rose(done_pulse) && !err_pulse |-> complete_code == 16'h0000; endproperty
   a_ok: assert property (p_ok) else $error("nonzero code on good finish");
   property p_bad; $rose(err_pulse) |-> complete_code != 16'h0000; endproperty
   a_bad: assert property (p_bad) else $error("zero code on fault");
   property p_rdy; !busy && module_ready_flag |=> !(save_start || init_start); endproperty
   a_rdy: assert property (p_rdy) else $error("start while ready high");
   property p_one; save_start || init_start |-> busy && !$past(busy); endproperty
   a_one: assert property (p_one) else $error("start while busy");
   property p_sys; system_word == 16'h0000; endproperty
   a_sys: assert property (p_sys) else $error("system word not zero");
endmodule : pfs_flash_ctrl_asserts
bind pfs_flash_ctrl pfs_flash_ctrl_asserts u_chk (.clk, .rst_n, .module_ready_flag, .scan_end,
   .save_start, .init_start, .busy, .done_pulse, .err_pulse, .complete_code, .system_word);
`default_nettype wire

//--- sim/test_pfs_flash_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// =========================================
// bench for save and factory init
module test_pfs_flash_ctrl;
   logic clk = 0, rst_n = 0, sv = 0, in = 0, tw = 0, rdy = 0, hr = 1, fl = 0, er = 0, torn = 0;
   logic [7:0] bs = 8'h00;
   logic s_go, i_go, ed, ef, se, busy, lk, pe, dp, ep;
   logic [15:0] cc, sw;
   int failures = 0, num_checks = 0;
   // block, engine and clock
   pfs_flash_ctrl dut (.clk, .rst_n, .flash_save_command(sv), .factory_init_command(in),
      .tool_write_command(tw), .module_base_select(bs), .scan_end(se), .error_reset(er),
      .module_ready_flag(rdy), .host_ready_output(hr), .save_start(s_go), .init_start(i_go),
      .engine_done(ed), .engine_fail(ef), .save_torn(torn), .busy, .write_locked(lk),
      .param_error(pe), .done_pulse(dp), .err_pulse(ep), .complete_code(cc), .system_word(sw));
   pfs_engine_model fm (.clk, .rst_n, .save_start(s_go), .init_start(i_go), .fail(fl),
      .engine_done(ed), .engine_fail(ef), .scan_end(se));
   initial forever #50 clk = ~clk;
   // compare and count
   task chk(string nm, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task print_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // bounded wait for done level
   task wait_dp(logic lvl);
      int n;
      n = 0;
      while (dp !== lvl && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 500)
      begin
         failures++;
         print_verdict;
      end
   endtask : wait_dp
   // one command, then result check
   // mode 0 init, 1 save, 2 tool write
   task run(logic [1:0] m, logic f, logic [15:0] c);
      fl = f;
      sv = (m == 2'd1);
      in = (m == 2'd0);
      tw = (m == 2'd2);
      @(negedge clk);
      sv = 0;
      in = 0;
      tw = 0;
      wait_dp(1);
      chk("err", 16'(ep), 16'(c != 16'h0));
      chk("code", cc, c);
      wait_dp(0);
   endtask : run
   // main sequence
   initial
   begin
      repeat (10) @(negedge clk);
      rst_n = 1;
      rdy = 1;
      sv = 1;
      repeat (20) @(negedge clk);
      chk("busy", 16'(busy), 16'h0);
      sv = 0;
      hr = 0;
      @(negedge clk);
      rdy = 0;
      bs = 8'h01;
      sv = 1;
      repeat (3) @(negedge clk);
      chk("busy", 16'(busy), 16'h0);
      sv = 0;
      bs = 8'h00;
      for (int k = 0; k < 25; k++)
         run({1'b0, k[0]}, 1'b0, 16'h0);
      run(2'd1, 1'b0, 16'h0325);
      run(2'd0, 1'b0, 16'h0325);
      run(2'd2, 1'b0, 16'h0);
      chk("lock", 16'(lk), 16'h1);
      er = 1;
      @(negedge clk);
      er = 0;
      chk("lock", 16'(lk), 16'h0);
      // reset only between commands, never during a save
      rst_n = 0;
      repeat (2) @(negedge clk);
      rst_n = 1;
      run(2'd1, 1'b1, 16'h0327);
      torn = 1;
      @(negedge clk);
      torn = 0;
      chk("perr", 16'(pe), 16'h1);
      run(2'd1, 1'b0, 16'h0);
      chk("perr", 16'(pe), 16'h0);
      chk("sysw", sw, 16'h0);
      print_verdict;
   end
endmodule : test_pfs_flash_ctrl
`default_nettype wire

//--- src/pfs_flash_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "pfs_map.svh"

module pfs_flash_ctrl
   import pfs_pkg::*;
#(
   parameter int BASE_SELF   = 8'h00,
   parameter int ENDURANCE   = `PFS_ENDURANCE,
   parameter int WRITE_LIMIT = `PFS_PROG_WRITE_LIMIT
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,

   // host commands
   input  wire logic        flash_save_command,
   input  wire logic        factory_init_command,
   input  wire logic        tool_write_command,
   input  wire logic [7:0]  module_base_select,
   input  wire logic        scan_end,
   input  wire logic        error_reset,

   // interlock
   input  wire logic        module_ready_flag,
   input  wire logic        host_ready_output,

   // flash and buffer engine
   output logic             save_start,
   output logic             init_start,
   input  wire logic        engine_done,
   input  wire logic        engine_fail,
   input  wire logic        save_torn,

   // results
   output logic             busy,
   output logic             write_locked,
   output logic             param_error,
   output logic             done_pulse,
   output logic             err_pulse,
   output logic [15:0]      complete_code,
   output logic [15:0]      system_word
);

   // =========================================
   // state
   typedef enum logic [2:0] {
      S_IDLE,
      S_RUN,
      S_WAIT_END,
      S_PULSE
   } pfs_state_t;

   // sequencer
   pfs_state_t  state, next_state;
   pfs_cmd_t    cmd, next_cmd;
   logic        tool, next_tool;

   // write counters
   logic [4:0]  prog_cnt, next_prog_cnt;
   logic [16:0] life_cnt, next_life_cnt;

   // sticky flags
   logic        locked, next_locked;
   logic        perr, next_perr;

   // result and engine strobes
   logic        fault, next_fault;
   logic [15:0] code, next_code;
   logic        s_start, next_s_start;
   logic        i_start, next_i_start;
   pfs_result_t res, next_res;

   // target check against this module's base number
   function automatic logic addressed(input logic [7:0] sel);
      addressed = (sel <= `PFS_BASE_MAX) && (sel == BASE_SELF[7:0]);
   endfunction : addressed

   // =========================================
   // request decode
   logic req_any;
   logic ok_ready;
   logic over_prog;
   logic over_life;
   logic accept;
   logic tool_req;
   logic limit_hit;

   // qualify the incoming request
   always_comb
   begin
      req_any   = (flash_save_command || factory_init_command || tool_write_command)
                  && addressed(module_base_select);
      ok_ready  = !module_ready_flag && !host_ready_output;
      over_prog = !tool_write_command && (prog_cnt >= WRITE_LIMIT[4:0]);
      over_life = (life_cnt >= ENDURANCE[16:0]);
      accept    = (state == S_IDLE) && req_any && ok_ready;
      tool_req  = tool_write_command && !flash_save_command && !factory_init_command;
      limit_hit = accept && !tool_req && (locked || over_prog);
   end

   // =========================================
   // lock and parameter error flags

   // set beats clear when both land together
   always_comb
   begin
      next_locked = locked;
      next_perr   = perr;
      if (error_reset)
         next_locked = 1'b0;
      if (limit_hit)
         next_locked = 1'b1;
      if ((state == S_RUN) && engine_done && !engine_fail)
         next_perr = 1'b0;
      if (save_torn)
         next_perr = 1'b1;
   end

   // flag registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         locked <= 1'b0;
         perr   <= 1'b0;
      end
      else
      begin
         locked <= next_locked;
         perr   <= next_perr;
      end
   end

   // =========================================
   // write counters

   // program writes and lifetime writes
   always_comb
   begin
      next_prog_cnt = prog_cnt;
      next_life_cnt = life_cnt;
      if (accept && !limit_hit && !over_life)
      begin
         if (!tool_req)
            next_prog_cnt = prog_cnt + 5'd1;
         next_life_cnt = life_cnt + 17'd1;
      end
   end

   // counter registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prog_cnt <= 5'h00;
         life_cnt <= 17'h00000;
      end
      else
      begin
         prog_cnt <= next_prog_cnt;
         life_cnt <= next_life_cnt;
      end
   end

   // =========================================
   // command sequencer

   // next state
   always_comb
   begin
      next_state    = state;
      next_cmd      = cmd;
      next_tool     = tool;
      next_fault    = fault;
      next_code     = code;
      next_s_start  = 1'b0;
      next_i_start  = 1'b0;
      next_res      = res;
      case (state)
         // wait for a qualified request
         S_IDLE:
         begin
            if (accept)
            begin
               next_cmd  = flash_save_command ? PFS_CMD_SAVE :
                           (factory_init_command ? PFS_CMD_INIT : PFS_CMD_SAVE);
               next_tool = tool_req;
               if (limit_hit)
               begin
                  next_fault  = 1'b1;
                  next_code   = `PFS_CODE_WRITE_LIMIT;
                  next_state  = S_WAIT_END;
               end
               else if (over_life)
               begin
                  next_fault = 1'b1;
                  next_code  = `PFS_CODE_WORN;
                  next_state = S_WAIT_END;
               end
               else
               begin
                  next_s_start  = (next_cmd == PFS_CMD_SAVE);
                  next_i_start  = (next_cmd == PFS_CMD_INIT);
                  next_fault    = 1'b0;
                  next_state    = S_RUN;
               end
            end
         end

         // engine copy or restore in flight
         S_RUN:
         begin
            if (engine_done)
            begin
               next_fault = engine_fail;
               next_code  = engine_fail ? `PFS_CODE_BAD_SAVE : `PFS_CODE_OK;
               next_state = S_WAIT_END;
            end
         end

         // raise the result at the next scan end
         S_WAIT_END:
         begin
            if (scan_end)
            begin
               next_res.done = 1'b1;
               next_res.err  = fault;
               next_res.code = code;
               next_state    = S_PULSE;
            end
         end

         // drop the result at the following scan end
         S_PULSE:
         begin
            if (scan_end)
            begin
               next_res.done = 1'b0;
               next_res.err  = 1'b0;
               next_state    = S_IDLE;
            end
         end

         default:
            next_state = S_IDLE;
      endcase
   end

   // =========================================
   // sequencer registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state    <= S_IDLE;
         cmd      <= PFS_CMD_NONE;
         tool     <= 1'b0;
         fault    <= 1'b0;
         code     <= 16'h0000;
         s_start  <= 1'b0;
         i_start  <= 1'b0;
         res      <= '0;
      end
      else
      begin
         state    <= next_state;
         cmd      <= next_cmd;
         tool     <= next_tool;
         fault    <= next_fault;
         code     <= next_code;
         s_start  <= next_s_start;
         i_start  <= next_i_start;
         res      <= next_res;
      end
   end

   // =========================================
   // outputs
   assign save_start    = s_start;
   assign init_start    = i_start;
   assign busy          = (state != S_IDLE);
   assign write_locked  = locked;
   assign param_error   = perr;
   assign done_pulse    = res.done;
   assign err_pulse     = res.err;
   assign complete_code = res.code;
   assign system_word   = 16'h0000;

endmodule : pfs_flash_ctrl
`default_nettype wire

//--- src/pfs_map.svh
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// =========================================
// completion codes
`define PFS_CODE_OK          16'h0000
`define PFS_CODE_WRITE_LIMIT 16'h0325
`define PFS_CODE_WORN        16'h0326
`define PFS_CODE_BAD_SAVE    16'h0327

// =========================================
// limits and sizes
`define PFS_PROG_WRITE_LIMIT 25
`define PFS_ENDURANCE        100000
`define PFS_PARAM_LAST       57
`define PFS_PARAM_EXTRA      150
`define PFS_POS_FIRST        1
`define PFS_POS_LAST         600
`define PFS_BLK_FIRST        7000
`define PFS_BLK_LAST         7004
`define PFS_BASE_MAX         8'hfe

`endif

//--- src/pfs_pkg.sv
package pfs_pkg;

   // =========================================
   // types
   typedef enum logic [1:0] {
      PFS_CMD_NONE,
      PFS_CMD_SAVE,
      PFS_CMD_INIT
   } pfs_cmd_t;

   typedef struct packed {
      logic        done;
      logic        err;
      logic [15:0] code;
   } pfs_result_t;

endpackage : pfs_pkg
